// [rtl/lsc_regs_top.sv]
// Functional notes
// - each sink register holds a 7-bit code in bits 6:0 setting that LED's current.
// - code zero gives 0 mA, all ones 30 mA; linear law steps 0.236 mA.
// - LED1 sink code register sits at index 0x1A.
// - comparator configuration register sits at index 0x1B.
// - filter field bits 7:5 select 80 ms doubling per code to 10,240 ms.
// - writing one to force bit starts a sensor read when sinks run, backlight off.
// - force bit self-clears once conversion ends and both results are valid.
// - a force request is ignored while the backlight is enabled.
// - bit 3 reads the upper level comparator result, read-only.
// - bit 2 reads the middle level comparator result, read-only.
// - bit 1 enables the upper level comparator.
// - bit 0 enables the middle level comparator.
// - upper level result wins over middle level when both trip.
// - LED2 sink code register sits at index 0x19.
// - sensor below middle threshold trips middle level, selecting office brightness.
`include "lsc_regs.svh"
module lsc_regs_top
    import lsc_pkg::*;
#(
    parameter logic [31:0] SENSOR_FILTER_TIME_BASE_CYC = `LSC_SENSOR_FILTER_TIME_BASE_MS * 1000 * `LSC_CLK_MHZ
) (
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic hresp,
    output logic [31:0] hrdata,
    input wire logic [7:0] light_sensor_input,
    output logic [6:0] led1_current_code,
    output logic [6:0] led2_current_code,
    output logic [14:0] led1_sink_ua,
    output logic [14:0] led2_sink_ua,
    output logic [1:0] light_level,
    output logic irq
);
    // ----------------------------------------
    // state
    // ----------------------------------------
    lsc_code_t led1_ff, led2_ff, nxt_led1, nxt_led2;
    logic [14:0] ua1_ff, ua2_ff, nxt_ua1, nxt_ua2;
    logic [2:0] sensor_filter_time_ff, nxt_sensor_filter_time, ctrl_ff, nxt_ctrl;
    logic force_ff, nxt_force, up_en_ff, nxt_up_en, mid_en_ff, nxt_mid_en;
    logic up_res_ff, nxt_up_res, mid_res_ff, nxt_mid_res;
    logic [15:0] thr_ff, nxt_thr;
    logic [1:0] stat_ff, nxt_stat, mask_ff, nxt_mask, level_ff, nxt_level;
    lsc_state_e state_ff, nxt_state;
    logic [31:0] cnt_ff, nxt_cnt, target;
    logic dp_wr_ff, nxt_dp_wr, dp_rd_ff, nxt_dp_rd, rd_ok_ff, nxt_rd_ok;
    logic [7:0] dp_idx_ff, nxt_dp_idx;
    logic [31:0] rdata_ff, nxt_rdata;
    logic ap, done, wr_cfg, bl_en, sink_run;
    logic [1:0] ev;
    logic [31:0] rd_val;

    // code to sink current in microamps, linear or square law
    function automatic logic [14:0] lsc_ua(input logic [6:0] c, input logic sq);
        logic [28:0] p;
        p = 29'(c) * 29'(c) * 29'(`LSC_FULL_UA);
        if (c == `LSC_CODE_MAX)
            lsc_ua = 15'(`LSC_FULL_UA);
        else if (sq)
            lsc_ua = 15'(p / 29'(`LSC_CODE_MAX_SQ));
        else
            lsc_ua = 15'(15'(c) * 15'(`LSC_STEP_UA));
    endfunction

    // ----------------------------------------
    // combinational helpers
    // ----------------------------------------
    assign ap = hsel & htrans[1] & hready;
    assign bl_en = ctrl_ff[`LSC_CTRL_BL_EN];
    assign sink_run = ctrl_ff[`LSC_CTRL_SINK_RUN];
    assign wr_cfg = dp_wr_ff && dp_idx_ff == `LSC_IDX_CFG;
    assign target = SENSOR_FILTER_TIME_BASE_CYC << sensor_filter_time_ff;
    assign done = state_ff == LSC_CONV && cnt_ff == target - 32'h1;
    assign hreadyout = ~(dp_rd_ff & ~rd_ok_ff); // reads take one wait state
    assign hresp = 1'b0;
    assign hrdata = rdata_ff;
    assign led1_current_code = led1_ff;
    assign led2_current_code = led2_ff;
    assign led1_sink_ua = ua1_ff;
    assign led2_sink_ua = ua2_ff;
    assign light_level = level_ff;
    assign irq = |(stat_ff & mask_ff);

    // read mux, unmapped reads return zero
    always_comb begin
        case (dp_idx_ff)
            `LSC_IDX_LED2: rd_val = {25'h0, led2_ff};
            `LSC_IDX_LED1: rd_val = {25'h0, led1_ff};
            `LSC_IDX_CFG: rd_val = {24'h0, sensor_filter_time_ff, force_ff, up_res_ff, mid_res_ff, up_en_ff, mid_en_ff};
            `LSC_IDX_CTRL: rd_val = {29'h0, ctrl_ff};
            `LSC_IDX_THR: rd_val = {16'h0, thr_ff};
            `LSC_IDX_STAT: rd_val = {30'h0, stat_ff};
            `LSC_IDX_MASK: rd_val = {30'h0, mask_ff};
            default: rd_val = 32'h0;
        endcase
    end

    // ----------------------------------------
    // next-state logic: bus, registers, conversion
    // ----------------------------------------
    always_comb begin
        nxt_dp_wr = ap & hwrite;
        nxt_dp_rd = ap ? ~hwrite : dp_rd_ff & ~rd_ok_ff;
        nxt_rd_ok = dp_rd_ff & ~rd_ok_ff & ~ap;
        nxt_dp_idx = ap ? haddr[9:2] : dp_idx_ff;
        nxt_rdata = (dp_rd_ff & ~rd_ok_ff) ? rd_val : rdata_ff;
        nxt_led1 = led1_ff;
        nxt_led2 = led2_ff;
        nxt_sensor_filter_time = sensor_filter_time_ff;
        nxt_ctrl = ctrl_ff;
        nxt_thr = thr_ff;
        nxt_mask = mask_ff;
        nxt_up_en = up_en_ff;
        nxt_mid_en = mid_en_ff;
        nxt_force = force_ff;
        nxt_state = state_ff;
        nxt_cnt = cnt_ff;
        nxt_up_res = up_res_ff;
        nxt_mid_res = mid_res_ff;
        ev = 2'h0;
        // register writes; bit 7 of sink registers is dropped
        if (dp_wr_ff) begin
            case (dp_idx_ff)
                `LSC_IDX_LED2: nxt_led2 = hwdata[6:0];
                `LSC_IDX_LED1: nxt_led1 = hwdata[6:0];
                `LSC_IDX_CFG: begin
                    nxt_sensor_filter_time = hwdata[`LSC_CFG_SENSOR_FILTER_TIME_HI:`LSC_CFG_SENSOR_FILTER_TIME_LO];
                    nxt_up_en = hwdata[`LSC_CFG_UP_EN];
                    nxt_mid_en = hwdata[`LSC_CFG_MID_EN];
                end
                `LSC_IDX_CTRL: nxt_ctrl = hwdata[2:0];
                `LSC_IDX_THR: nxt_thr = hwdata[15:0];
                `LSC_IDX_MASK: nxt_mask = hwdata[1:0];
                default: ;
            endcase
        end
        // forced read request
        if (wr_cfg && hwdata[`LSC_CFG_FORCE] && !force_ff) begin
            if (bl_en)
                ev[`LSC_EV_IGNORED] = 1'b1;
            else if (sink_run && state_ff == LSC_IDLE) begin
                nxt_force = 1'b1;
                nxt_state = LSC_CONV;
                nxt_cnt = 32'h0;
            end
        end
        // conversion sequencing
        case (state_ff)
            LSC_IDLE: begin
                if (bl_en && (up_en_ff || mid_en_ff)) begin
                    nxt_state = LSC_CONV; // periodic sampling while backlight on
                    nxt_cnt = 32'h0;
                end
            end
            LSC_CONV: begin
                nxt_cnt = cnt_ff + 32'h1;
                if (done) begin
                    nxt_state = LSC_IDLE;
                    nxt_up_res = up_en_ff && light_sensor_input < thr_ff[15:8];
                    nxt_mid_res = mid_en_ff && light_sensor_input < thr_ff[7:0];
                    nxt_force = 1'b0;
                    ev[`LSC_EV_DONE] = 1'b1;
                end
            end
            default: nxt_state = LSC_IDLE;
        endcase
        // disabled comparators report no trip
        if (!nxt_up_en)
            nxt_up_res = 1'b0;
        if (!nxt_mid_en)
            nxt_mid_res = 1'b0;
        // upper level takes priority
        nxt_level = nxt_up_res ? 2'h2 : (nxt_mid_res ? 2'h1 : 2'h0);
        // sticky events, write one to clear, set wins
        nxt_stat = stat_ff;
        if (dp_wr_ff && dp_idx_ff == `LSC_IDX_STAT)
            nxt_stat = stat_ff & ~hwdata[1:0];
        nxt_stat = nxt_stat | ev;
        nxt_ua1 = lsc_ua(nxt_led1, nxt_ctrl[`LSC_CTRL_SQ_LAW]);
        nxt_ua2 = lsc_ua(nxt_led2, nxt_ctrl[`LSC_CTRL_SQ_LAW]);
    end

    // ----------------------------------------
    // registers
    // ----------------------------------------
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            led1_ff <= `LSC_RST_CODE;
            led2_ff <= `LSC_RST_CODE;
            ua1_ff <= 15'h0;
            ua2_ff <= 15'h0;
            {sensor_filter_time_ff, force_ff, up_res_ff, mid_res_ff, up_en_ff, mid_en_ff} <= `LSC_RST_CFG;
            ctrl_ff <= `LSC_RST_CTRL;
            thr_ff <= `LSC_RST_THR;
            stat_ff <= `LSC_RST_EV;
            mask_ff <= `LSC_RST_EV;
            level_ff <= 2'h0;
            state_ff <= LSC_IDLE;
            cnt_ff <= 32'h0;
            dp_wr_ff <= 1'b0;
            dp_rd_ff <= 1'b0;
            rd_ok_ff <= 1'b0;
            dp_idx_ff <= 8'h00;
            rdata_ff <= 32'h0;
        end else begin
            led1_ff <= nxt_led1;
            led2_ff <= nxt_led2;
            ua1_ff <= nxt_ua1;
            ua2_ff <= nxt_ua2;
            sensor_filter_time_ff <= nxt_sensor_filter_time;
            force_ff <= nxt_force;
            up_res_ff <= nxt_up_res;
            mid_res_ff <= nxt_mid_res;
            up_en_ff <= nxt_up_en;
            mid_en_ff <= nxt_mid_en;
            ctrl_ff <= nxt_ctrl;
            thr_ff <= nxt_thr;
            stat_ff <= nxt_stat;
            mask_ff <= nxt_mask;
            level_ff <= nxt_level;
            state_ff <= nxt_state;
            cnt_ff <= nxt_cnt;
            dp_wr_ff <= nxt_dp_wr;
            dp_rd_ff <= nxt_dp_rd;
            rd_ok_ff <= nxt_rd_ok;
            dp_idx_ff <= nxt_dp_idx;
            rdata_ff <= nxt_rdata;
        end
    end

    // ----------------------------------------
    // assertions
    // ----------------------------------------
    chk_led1_write: assert property (@(posedge sys_clk) disable iff (!rst_n)
        dp_wr_ff && dp_idx_ff == 8'h1A |=> led1_current_code == $past(hwdata[6:0]))
        else $error("led1 code not written");
    chk_led2_write: assert property (@(posedge sys_clk) disable iff (!rst_n)
        dp_wr_ff && dp_idx_ff == 8'h19 |=> led2_current_code == $past(hwdata[6:0]))
        else $error("led2 code not written");
    chk_resv_reads_zero: assert property (@(posedge sys_clk) disable iff (!rst_n)
        dp_rd_ff && !rd_ok_ff && (dp_idx_ff == 8'h19 || dp_idx_ff == 8'h1A) |=> hrdata[31:7] == 25'h0)
        else $error("reserved sink bits not zero");
    chk_ua_ends: assert property (@(posedge sys_clk) disable iff (!rst_n)
        (led1_current_code == 7'h00 |-> led1_sink_ua == 15'h0)
        and (led1_current_code == 7'h7F |-> led1_sink_ua == 15'd30000))
        else $error("sink current end points wrong");
    chk_sensor_filter_time_span: assert property (@(posedge sys_clk) disable iff (!rst_n)
        state_ff == LSC_CONV && cnt_ff == (SENSOR_FILTER_TIME_BASE_CYC << sensor_filter_time_ff) - 32'h1 |=> state_ff == LSC_IDLE)
        else $error("filter time not honoured");
    chk_force_start: assert property (@(posedge sys_clk) disable iff (!rst_n)
        wr_cfg && hwdata[4] && !force_ff && !bl_en && sink_run && state_ff == LSC_IDLE
        |=> force_ff && state_ff == LSC_CONV)
        else $error("forced read did not start");
    chk_force_clear: assert property (@(posedge sys_clk) disable iff (!rst_n)
        $fell(force_ff) |-> $past(done) && state_ff == LSC_IDLE)
        else $error("force bit cleared early");
    chk_force_ignored: assert property (@(posedge sys_clk) disable iff (!rst_n)
        wr_cfg && hwdata[4] && !force_ff && bl_en |=> !force_ff ##0 stat_ff[1])
        else $error("force accepted with backlight on");
    chk_result_read: assert property (@(posedge sys_clk) disable iff (!rst_n)
        dp_rd_ff && !rd_ok_ff && dp_idx_ff == 8'h1B |=> hrdata[3:2] == {$past(up_res_ff), $past(mid_res_ff)})
        else $error("result bits misread");
    chk_upper_gate: assert property (@(posedge sys_clk) disable iff (!rst_n)
        !up_en_ff |-> !up_res_ff)
        else $error("upper result with comparator off");
    chk_middle_gate: assert property (@(posedge sys_clk) disable iff (!rst_n)
        !mid_en_ff |-> !mid_res_ff)
        else $error("middle result with comparator off");
    chk_level_prio: assert property (@(posedge sys_clk) disable iff (!rst_n)
        (up_res_ff |-> light_level == 2'h2) and (!up_res_ff && mid_res_ff |-> light_level == 2'h1))
        else $error("level priority wrong");
    chk_middle_trip: assert property (@(posedge sys_clk) disable iff (!rst_n)
        done && mid_en_ff && light_sensor_input < thr_ff[7:0] && !wr_cfg |=> mid_res_ff)
        else $error("middle level did not trip");
    // result capture, force hold, linear law and read wait state
    chk_upper_trip: assert property (@(posedge sys_clk) disable iff (!rst_n)
        done && up_en_ff && light_sensor_input < thr_ff[15:8] && !wr_cfg |=> up_res_ff)
        else $error("upper level did not trip");
    chk_force_hold: assert property (@(posedge sys_clk) disable iff (!rst_n)
        force_ff && !done |=> force_ff)
        else $error("force bit dropped before conversion end");
    chk_force_blocked: assert property (@(posedge sys_clk) disable iff (!rst_n)
        bl_en && !force_ff |=> !force_ff)
        else $error("force bit set with backlight on");
    chk_sink_linear: assert property (@(posedge sys_clk) disable iff (!rst_n)
        !ctrl_ff[`LSC_CTRL_SQ_LAW] && led1_current_code != 7'h7F |-> led1_sink_ua == 15'(led1_current_code) * 15'(`LSC_STEP_UA))
        else $error("linear sink current wrong");
    chk_read_wait: assert property (@(posedge sys_clk) disable iff (!rst_n)
        ap && !hwrite |=> !hreadyout ##1 hreadyout)
        else $error("read wait state wrong");
endmodule

// [pkg/lsc_regs.svh]
`ifndef LSC_REGS_SVH
`define LSC_REGS_SVH
// ----------------------------------------
// register indices (byte address = index * 4)
// ----------------------------------------
`define LSC_IDX_LED2 8'h19
`define LSC_IDX_LED1 8'h1A
`define LSC_IDX_CFG 8'h1B
`define LSC_IDX_CTRL 8'h20
`define LSC_IDX_THR 8'h21
`define LSC_IDX_STAT 8'h22
`define LSC_IDX_MASK 8'h23
// ----------------------------------------
// field positions
// ----------------------------------------
`define LSC_CFG_SENSOR_FILTER_TIME_HI 7
`define LSC_CFG_SENSOR_FILTER_TIME_LO 5
`define LSC_CFG_FORCE 4
`define LSC_CFG_UP_RES 3
`define LSC_CFG_MID_RES 2
`define LSC_CFG_UP_EN 1
`define LSC_CFG_MID_EN 0
`define LSC_CTRL_BL_EN 0
`define LSC_CTRL_SINK_RUN 1
`define LSC_CTRL_SQ_LAW 2
`define LSC_EV_DONE 0
`define LSC_EV_IGNORED 1
// ----------------------------------------
// reset values
// ----------------------------------------
`define LSC_RST_CODE 7'h00
`define LSC_RST_CFG 8'h00
`define LSC_RST_CTRL 3'h0
`define LSC_RST_THR 16'h0000
`define LSC_RST_EV 2'h0
// ----------------------------------------
// timing and current scale
// ----------------------------------------
`define LSC_CLK_MHZ 200
`define LSC_SENSOR_FILTER_TIME_BASE_MS 80
`define LSC_STEP_UA 236
`define LSC_FULL_UA 30000
`define LSC_CODE_MAX 7'h7F
`define LSC_CODE_MAX_SQ 16129
`endif

// [pkg/lsc_pkg.sv]
package lsc_pkg;
    typedef enum logic [1:0] {
        LSC_IDLE = 2'b01,
        LSC_CONV = 2'b10
    } lsc_state_e;
    typedef logic [6:0] lsc_code_t;
endpackage

// [dv/lsc_sensor_model.sv]
// ----------------------------------------
// ambient light sensor model
// ----------------------------------------
module lsc_sensor_model (
    input wire logic sys_clk,
    input wire logic [7:0] level_set,
    output logic [7:0] light_sensor_input
);
    timeunit 1ns;
    timeprecision 1ps;
    // sensor level follows the requested light one clock late, like a slow photodiode
    always_ff @(posedge sys_clk) begin
        light_sensor_input <= level_set;
    end
endmodule

// [dv/tb.sv]
`include "lsc_regs.svh"
module tb;
    timeunit 1ns;
    timeprecision 1ps;
    import lsc_pkg::*;
    logic sys_clk = 1'b0, rst_n = 1'b0, hsel = 1'b0, hwrite = 1'b0;
    logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, rd;
    logic [1:0] htrans = 2'b00, light_level;
    logic hreadyout, hresp, irq;
    logic [7:0] level_set = 8'h60, light_sensor_input;
    logic [6:0] led1_current_code, led2_current_code;
    logic [14:0] led1_sink_ua, led2_sink_ua;
    int errors = 0, checks_done = 0;
    lsc_regs_top #(.SENSOR_FILTER_TIME_BASE_CYC(32'd4)) lsc_regs_top_i (.sys_clk(sys_clk), .rst_n(rst_n), .hsel(hsel),
        .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
        .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .light_sensor_input(light_sensor_input),
        .led1_current_code(led1_current_code), .led2_current_code(led2_current_code),
        .led1_sink_ua(led1_sink_ua), .led2_sink_ua(led2_sink_ua), .light_level(light_level), .irq(irq));
    lsc_sensor_model lsc_sensor_model_i (.sys_clk(sys_clk), .level_set(level_set),
        .light_sensor_input(light_sensor_input));
    // ----------------------------------------
    // clock, report and bus tasks
    // ----------------------------------------
    initial begin
        forever #2.5 sys_clk = ~sys_clk;
    end
    task automatic close_out();
        $display("checks %0d errors %0d", checks_done, errors);
        if (errors == 0 && checks_done > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
        checks_done++;
        if (got !== exp) begin
            errors++;
            $display("Error at %0t: %s got %h expected %h", $time, what, got, exp);
        end
    endtask
    // waits for hready sampled high at a rising edge, value taken before that edge updates
    task automatic wait_ready();
        int n;
        logic ok;
        n = 0;
        do begin
            @(negedge sys_clk);
            ok = (hreadyout === 1'b1);
            rd = hrdata;
            @(posedge sys_clk);
            n++;
        end while (!ok && n < 50);
        if (!ok) begin
            errors++;
            $display("Error at %0t: bus timeout", $time);
            close_out();
        end
    endtask
    task automatic bus(input logic wr, input logic [7:0] idx, input logic [31:0] wd);
        hsel <= 1'b1;
        htrans <= 2'b10;
        hwrite <= wr;
        haddr <= {22'h0, idx, 2'b00};
        wait_ready();
        hsel <= 1'b0;
        htrans <= 2'b00;
        hwdata <= wd;
        wait_ready();
    endtask
    // read-back sampled at the negedge before the taking edge
    task automatic rd_chk(input logic [7:0] idx, input logic [31:0] exp, input string what);
        bus(1'b0, idx, 32'h0);
        chk(rd, exp, what);
    endtask
    // ----------------------------------------
    // scenarios
    // ----------------------------------------
    task automatic t_reset();
        rd_chk(`LSC_IDX_LED1, 32'h0, "led1 reset");
        rd_chk(`LSC_IDX_LED2, 32'h0, "led2 reset");
        rd_chk(`LSC_IDX_CFG, 32'h0, "cfg reset");
        rd_chk(8'h3F, 32'h0, "unmapped read");
        chk(hresp, 32'h0, "okay response");
        chk(irq, 32'h0, "irq reset");
        $display("t_reset done");
    endtask
    task automatic t_sink();
        bus(1'b1, `LSC_IDX_LED1, 32'h0000_00FF);
        bus(1'b1, `LSC_IDX_LED2, 32'h0000_0003);
        rd_chk(`LSC_IDX_LED1, 32'h7F, "reserved bit7");
        chk(led1_current_code, 32'h7F, "led1 code");
        chk(led2_current_code, 32'h03, "led2 code pin");
        chk(led1_sink_ua, 32'd30000, "full scale");
        chk(led2_sink_ua, 32'd708, "linear step");
        bus(1'b1, `LSC_IDX_CTRL, 32'h0000_0006);
        rd_chk(`LSC_IDX_LED2, 32'h03, "led2 code");
        chk(led2_sink_ua, 32'd16, "square law");
        chk(led1_sink_ua, 32'd30000, "square full scale");
        bus(1'b1, `LSC_IDX_LED1, 32'h0000_0000);
        rd_chk(`LSC_IDX_LED1, 32'h00, "zero code");
        chk(led1_sink_ua, 32'd0, "zero current");
        $display("t_sink done");
    endtask
    // forced read with filter code 1 (8 cycles), polls the force bit clear
    task automatic force_read(input logic [7:0] lvl, input logic [31:0] exp_cfg);
        int n;
        level_set <= lvl;
        bus(1'b1, `LSC_IDX_CFG, 32'h0000_0033);
        n = 0;
        do begin
            bus(1'b0, `LSC_IDX_CFG, 32'h0);
            if (n == 0) begin
                chk(rd[4], 1'b1, "force started");
            end
            n++;
        end while (rd[4] !== 1'b0 && n < 40);
        chk(n < 40, 1'b1, "force self clear");
        chk(rd, exp_cfg, "cfg after force");
    endtask
    task automatic t_force();
        bus(1'b1, `LSC_IDX_CTRL, 32'h0000_0002);
        bus(1'b1, `LSC_IDX_THR, 32'h0000_4080);
        bus(1'b1, `LSC_IDX_MASK, 32'h0000_0001);
        force_read(8'h60, 32'h27);
        chk(light_level, 32'd1, "middle level");
        chk(irq, 1'b1, "done irq");
        force_read(8'h10, 32'h2F);
        chk(light_level, 32'd2, "upper priority");
        bus(1'b1, `LSC_IDX_CFG, 32'h0000_0001);
        rd_chk(`LSC_IDX_CFG, 32'h05, "upper disabled");
        chk(light_level, 32'd1, "middle after upper off");
        bus(1'b1, `LSC_IDX_CFG, 32'h0000_0000);
        rd_chk(`LSC_IDX_CFG, 32'h00, "middle disabled");
        rd_chk(`LSC_IDX_STAT, 32'h01, "status done");
        bus(1'b1, `LSC_IDX_STAT, 32'h0000_0001);
        rd_chk(`LSC_IDX_STAT, 32'h00, "status cleared");
        chk(irq, 1'b0, "irq cleared");
        $display("t_force done");
    endtask
    task automatic t_ignored();
        bus(1'b1, `LSC_IDX_CTRL, 32'h0000_0003);
        bus(1'b1, `LSC_IDX_CFG, 32'h0000_0010);
        rd_chk(`LSC_IDX_CFG, 32'h00, "force ignored");
        rd_chk(`LSC_IDX_STAT, 32'h02, "ignored event");
        chk(irq, 1'b0, "masked event");
        bus(1'b1, `LSC_IDX_MASK, 32'h0000_0002);
        @(posedge sys_clk);
        chk(irq, 1'b1, "unmasked event");
        // backlight on with middle enabled: periodic sampling
        bus(1'b1, `LSC_IDX_CFG, 32'h0000_0001);
        repeat (10) @(posedge sys_clk);
        rd_chk(`LSC_IDX_CFG, 32'h05, "periodic sample");
        chk(light_level, 32'd1, "periodic level");
        $display("t_ignored done");
    endtask
    initial begin
        repeat (3) @(posedge sys_clk);
        rst_n <= 1'b1;
        @(posedge sys_clk);
        t_reset();
        t_sink();
        t_force();
        t_ignored();
        close_out();
    end
endmodule
